//--- logic/rbc_pkg.sv
package rbc_pkg;
	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] RBC_CAUSE_ADDR  = 8'h00;
	localparam logic [7:0] RBC_OPTION_ADDR = 8'h04;
	localparam logic [7:0] RBC_FILTER_ADDR = 8'h08;
	localparam logic [7:0] RBC_CLKGEN_ADDR = 8'h0c;
	localparam logic [7:0] RBC_DEBUG_ADDR  = 8'h10;
	localparam logic [7:0] RBC_SWRST_ADDR  = 8'h14;
	localparam logic [7:0] RBC_BOOT_ADDR   = 8'h18;

	// ---------------------------------------------------------------
	// reset cause bit positions
	// ---------------------------------------------------------------
	localparam int RBC_NCAUSE   = 9;
	localparam int RBC_C_POR    = 0;
	localparam int RBC_C_LVD    = 1;
	localparam int RBC_C_PIN    = 2;
	localparam int RBC_C_WATCHDOG_TIMER   = 3;
	localparam int RBC_C_LOC    = 4;
	localparam int RBC_C_SACK   = 5;
	localparam int RBC_C_SW     = 6;
	localparam int RBC_C_LOCKUP = 7;
	localparam int RBC_C_DAP    = 8;

	// option register fields
	localparam int          RBC_OPT_RESET_PIN_ENABLE  = 0;
	localparam int          RBC_OPT_NMIE   = 1;
	localparam int          RBC_OPT_SWDE   = 2;
	localparam logic [2:0]  RBC_OPT_RESET  = 3'h7;
	// filter register: [12] clock select (1 = low power clock), [11:0] width-1
	localparam int          RBC_FLT_SEL    = 12;
	localparam logic [12:0] RBC_FLT_RESET  = 13'h0000;
	localparam int          RBC_FLT_LPMAX  = 127;
	// clock generator control: [0] monitor enable, [2:1] mode
	localparam int          RBC_CG_CME     = 0;
	// debug port control: [0] system reset request, [1] core hold
	localparam int          RBC_DBG_SYSREQ = 0;
	localparam int          RBC_DBG_HOLD   = 1;
	// software reset key
	localparam logic [15:0] RBC_SW_KEY     = 16'h05fa;

	// ---------------------------------------------------------------
	// boot vectors
	// ---------------------------------------------------------------
	localparam logic [31:0] RBC_VEC_SP     = 32'h0000_0000;
	localparam logic [31:0] RBC_VEC_PC     = 32'h0000_0004;
	localparam logic [31:0] RBC_LR_RESET   = 32'hffff_ffff;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int RBC_CLK_KHZ       = 50000;
	localparam int RBC_LPO_KHZ       = 20;
	localparam int RBC_PIN_DRIVE_NS  = 4200;
	localparam int RBC_FLASH_INIT_NS = 16000;
	localparam int RBC_PIN_DRIVE_CYC = (RBC_PIN_DRIVE_NS * RBC_CLK_KHZ + 999999) / 1000000;
	localparam int RBC_FLASH_CYC     = (RBC_FLASH_INIT_NS * RBC_CLK_KHZ + 999999) / 1000000;
	localparam int RBC_LPO_DIV       = RBC_CLK_KHZ / RBC_LPO_KHZ;
	localparam int RBC_SACK_LPO      = 1025;

	typedef enum logic [1:0] {
		RBC_MODE_INTERNAL  = 2'b00,
		RBC_MODE_FBE       = 2'b01,
		RBC_MODE_FEE       = 2'b10,
		RBC_MODE_BYPASSED_EXTERNAL_LOWPOWER     = 2'b11
	} rbc_clkmode_t;

	typedef enum logic [2:0] {
		RBC_ST_HOLD   = 3'b000,
		RBC_ST_DRIVE  = 3'b001,
		RBC_ST_WAITPIN= 3'b010,
		RBC_ST_FLASH  = 3'b011,
		RBC_ST_RUN    = 3'b100
	} rbc_state_t;

	// reset tiers carried together
	typedef struct packed {
		logic por_only;
		logic chip_por;
		logic early_chip;
		logic chip;
		logic core;
	} rbc_resets_t;

	// per-source reset requests
	typedef struct packed {
		logic lockup;
		logic sw;
		logic sack;
		logic loc;
		logic watchdog_timer;
		logic low_voltage_detect;
		logic por;
	} rbc_req_t;
endpackage : rbc_pkg

//--- logic/rbc_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_pin_filter
	import rbc_pkg::*;
#(
	parameter int WIDTH_BITS = 12
) (
	input  wire logic                  mclk_in,
	input  wire logic                  nrst_in,
	input  wire logic                  lpo_tick_in,
	input  wire logic                  use_lpo_in,
	input  wire logic [WIDTH_BITS-1:0] width_in,
	input  wire logic                  pin_in,
	output logic                       pin_out
);
	logic [WIDTH_BITS-1:0] count_reg;
	logic                  tick;
	logic [WIDTH_BITS-1:0] limit;

	// low power clock counts are capped at 128
	assign tick  = use_lpo_in ? lpo_tick_in : 1'b1;
	assign limit = (use_lpo_in && width_in > WIDTH_BITS'(RBC_FLT_LPMAX)) ? WIDTH_BITS'(RBC_FLT_LPMAX) : width_in;

	// a level must persist for width+1 ticks before it is passed on
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			count_reg <= '0;
			pin_out   <= 1'b1;
		end else if (pin_in == pin_out) begin
			count_reg <= '0;
		end else if (tick) begin
			if (count_reg >= limit) begin
				pin_out   <= pin_in;
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end
endmodule : rbc_pin_filter
`default_nettype wire

//--- logic/rbc_top.sv
// What this block does
// - every system reset source has its own sticky cause flag readable by software
// - power-on reset sets both power-on and low-voltage cause flags
// - core fetches stack pointer from offset 0, pc from 4, link register all ones
// - peripherals and pins start disabled except debug, nmi, reset per option register
// - shared pin is reset input after power-on; clearing enable frees it
// - pin glitch filter on bus or low power clock, 1-4096 or 1-128, one setting
// - watchdog reset sets the watchdog cause flag
// - clock monitor armed in FBE and FEE modes resets chip on loss, sets flag
// - stop request unacknowledged for 1025 low power clocks causes reset
// - software reset asserts early chip, chip and core tiers; debug and control registers keep their values
// - core lockup causes system reset and sets lockup flag
// - debug system reset request holds reset until the debugger clears it
// - debug core hold keeps core in reset after the chip leaves reset
// - por-only reset asserts only on power-on and triggers all other tiers
// - chip por asserts on power-on and low voltage, triggers lower tiers
// - early chip reset asserts on every source, releases as flash init begins
// - chip reset asserts on every source, releases after the pin releases
// - exit starts holding reset, driving pin low 4.2 us when it is the reset pin, enabling clock gen
// - after pin release, wait for pin high, then enable core clock
// - flash initialises 16 us with core halted, then core fetches vectors
// - boot from flash vectors 0x0 and 0x4, relocatable via vector offset
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rbc_top
	import rbc_pkg::*;
(
	input  wire logic                mclk_in,
	input  wire logic                nrst_in,
	// axi4-lite slave
	input  wire logic [7:0]          s_axi_awaddr_in,
	input  wire logic                s_axi_awvalid_in,
	output logic                     s_axi_awready_out,
	input  wire logic [31:0]         s_axi_wdata_in,
	input  wire logic [3:0]          s_axi_wstrb_in,
	input  wire logic                s_axi_wvalid_in,
	output logic                     s_axi_wready_out,
	output logic [1:0]               s_axi_bresp_out,
	output logic                     s_axi_bvalid_out,
	input  wire logic                s_axi_bready_in,
	input  wire logic [7:0]          s_axi_araddr_in,
	input  wire logic                s_axi_arvalid_in,
	output logic                     s_axi_arready_out,
	output logic [31:0]              s_axi_rdata_out,
	output logic [1:0]               s_axi_rresp_out,
	output logic                     s_axi_rvalid_out,
	input  wire logic                s_axi_rready_in,
	// reset requests
	input  wire rbc_pkg::rbc_req_t   req_in,
	input  wire logic                stop_req_in,
	input  wire logic                stop_ack_in,
	input  wire logic                ext_clk_lost_in,
	// shared reset pin
	input  wire logic                shared_reset_pin_in,
	output logic                     shared_reset_pin_out,
	output logic                     shared_reset_pin_oe_n_out,
	// resets and boot
	output rbc_pkg::rbc_resets_t     resets_out,
	output logic                     core_clk_en_out,
	output logic                     clkgen_default_out,
	output logic                     pins_enable_out,
	output logic [2:0]               pin_fn_enable_out,
	output logic                     vec_fetch_out,
	output logic [31:0]              vec_sp_addr_out,
	output logic [31:0]              vec_pc_addr_out,
	output logic [31:0]              lr_init_out
);
	import rbc_pkg::*;

	// ---------------------------------------------------------------
	// request synchronisers
	// ---------------------------------------------------------------
	localparam int NREQ = 9;
	logic [NREQ-1:0] raw_req;
	logic [NREQ-1:0] sync1_reg;
	logic [NREQ-1:0] sync2_reg;
	logic            lpo_tick_reg;
	logic [15:0]     lpo_cnt_reg;

	assign raw_req = {stop_ack_in, stop_req_in, ext_clk_lost_in, req_in.lockup, req_in.sw,
	                  req_in.watchdog_timer, req_in.low_voltage_detect, req_in.por, shared_reset_pin_in};

	// second stage alone reads the first
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw_req;
			sync2_reg <= sync1_reg;
		end
	end

	logic s_pin;
	logic s_por;
	logic s_lvd;
	logic s_watchdog_timer;
	logic s_sw;
	logic s_lockup;
	logic s_clklost;
	logic s_stop;
	logic s_ack;
	assign {s_ack, s_stop, s_clklost, s_lockup, s_sw, s_watchdog_timer, s_lvd, s_por, s_pin} = sync2_reg;

	// ---------------------------------------------------------------
	// low power clock enable
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			lpo_cnt_reg  <= '0;
			lpo_tick_reg <= 1'b0;
		end else if (lpo_cnt_reg == 16'(RBC_LPO_DIV - 1)) begin
			lpo_cnt_reg  <= '0;
			lpo_tick_reg <= 1'b1;
		end else begin
			lpo_cnt_reg  <= lpo_cnt_reg + 16'h0001;
			lpo_tick_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [RBC_NCAUSE-1:0] cause_reg;
	logic [2:0]            option_reg;
	logic [12:0]           filter_reg;
	logic [2:0]            clkgen_reg;
	logic [1:0]            debug_reg;
	logic                  sw_req_reg;
	logic [31:0]           vector_table_offset_reg_reg;
	logic                  pin_filt;
	logic                  sack_reg;
	logic [10:0]           sack_cnt_reg;
	logic                  pin_is_reset;
	rbc_state_t            state_reg;
	logic [9:0]            seq_cnt_reg;

	assign pin_is_reset = option_reg[RBC_OPT_RESET_PIN_ENABLE];

	rbc_pin_filter #(
		.WIDTH_BITS (12)
	) u_filter (
		.mclk_in     (mclk_in),
		.nrst_in     (nrst_in & ~resets_out.chip_por),
		.lpo_tick_in (lpo_tick_reg),
		.use_lpo_in  (filter_reg[RBC_FLT_SEL]),
		.width_in    (filter_reg[11:0]),
		.pin_in      (s_pin),
		.pin_out     (pin_filt)
	);

	// ---------------------------------------------------------------
	// reset sources
	// ---------------------------------------------------------------
	logic rbc_monitor_armed;
	logic src_pin;
	logic src_loc;
	logic src_any;
	logic src_chip_por;

	// monitor is dead when the fll is off in low power bypass
	assign rbc_monitor_armed = clkgen_reg[RBC_CG_CME] &&
	                           (clkgen_reg[2:1] == RBC_MODE_FBE || clkgen_reg[2:1] == RBC_MODE_FEE);
	assign src_loc      = rbc_monitor_armed && s_clklost;
	assign src_pin      = pin_is_reset && !pin_filt && state_reg == RBC_ST_RUN;
	assign src_chip_por = s_por || s_lvd;
	assign src_any      = src_chip_por || src_pin || s_watchdog_timer || src_loc || sack_reg ||
	                      sw_req_reg || s_lockup || s_sw || debug_reg[RBC_DBG_SYSREQ];

	// stop acknowledge watchdog counts low power clocks
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || resets_out.chip) begin
			sack_cnt_reg <= '0;
			sack_reg     <= 1'b0;
		end else if (!s_stop || s_ack) begin
			sack_cnt_reg <= '0;
		end else if (lpo_tick_reg) begin
			if (sack_cnt_reg == 11'(RBC_SACK_LPO - 1))
				sack_reg <= 1'b1;
			else
				sack_cnt_reg <= sack_cnt_reg + 11'h001;
		end
	end

	// ---------------------------------------------------------------
	// exit-from-reset sequencer
	// ---------------------------------------------------------------

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			state_reg   <= RBC_ST_HOLD;
			seq_cnt_reg <= '0;
		end else if (src_any) begin
			state_reg   <= RBC_ST_HOLD;
			seq_cnt_reg <= '0;
		end else begin
			case (state_reg)
				RBC_ST_HOLD: begin
					state_reg   <= RBC_ST_DRIVE;
					seq_cnt_reg <= '0;
				end
				RBC_ST_DRIVE: begin
					if (seq_cnt_reg == 10'(RBC_PIN_DRIVE_CYC - 1)) begin
						state_reg   <= RBC_ST_WAITPIN;
						seq_cnt_reg <= '0;
					end else
						seq_cnt_reg <= seq_cnt_reg + 10'h001;
				end
				RBC_ST_WAITPIN: begin
					if (s_pin || !pin_is_reset)
						state_reg <= RBC_ST_FLASH;
				end
				RBC_ST_FLASH: begin
					if (seq_cnt_reg == 10'(RBC_FLASH_CYC - 1)) begin
						state_reg   <= RBC_ST_RUN;
						seq_cnt_reg <= '0;
					end else
						seq_cnt_reg <= seq_cnt_reg + 10'h001;
				end
				RBC_ST_RUN: state_reg <= RBC_ST_RUN;
				default:    state_reg <= RBC_ST_HOLD;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// reset tiers
	// ---------------------------------------------------------------
	logic core_hold;

	assign core_hold = src_any || state_reg != RBC_ST_RUN || debug_reg[RBC_DBG_HOLD];

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			resets_out <= '1;
		end else begin
			resets_out.por_only   <= s_por;
			resets_out.chip_por   <= src_chip_por;
			// early tier lets flash go as initialisation begins
			resets_out.early_chip <= src_any || state_reg == RBC_ST_HOLD ||
			                         state_reg == RBC_ST_DRIVE || state_reg == RBC_ST_WAITPIN;
			resets_out.chip       <= src_any || state_reg == RBC_ST_HOLD ||
			                         state_reg == RBC_ST_DRIVE || state_reg == RBC_ST_WAITPIN;
			resets_out.core       <= core_hold;
		end
	end

	// ---------------------------------------------------------------
	// pin and boot outputs
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			shared_reset_pin_out      <= 1'b0;
			shared_reset_pin_oe_n_out <= 1'b1;
			core_clk_en_out           <= 1'b0;
			clkgen_default_out        <= 1'b1;
			pins_enable_out           <= 1'b0;
			pin_fn_enable_out         <= '0;
			vec_fetch_out             <= 1'b0;
			vec_sp_addr_out           <= RBC_VEC_SP;
			vec_pc_addr_out           <= RBC_VEC_PC;
			lr_init_out               <= RBC_LR_RESET;
		end else begin
			shared_reset_pin_out      <= 1'b0;
			shared_reset_pin_oe_n_out <= !(state_reg == RBC_ST_DRIVE && pin_is_reset);
			core_clk_en_out           <= state_reg == RBC_ST_FLASH || state_reg == RBC_ST_RUN;
			clkgen_default_out        <= state_reg != RBC_ST_RUN;
			pins_enable_out           <= 1'b0;
			pin_fn_enable_out         <= option_reg;
			// fetch follows the core's own release, so a debug hold delays it
			vec_fetch_out             <= resets_out.core && !core_hold;
			vec_sp_addr_out           <= vector_table_offset_reg_reg + RBC_VEC_SP;
			vec_pc_addr_out           <= vector_table_offset_reg_reg + RBC_VEC_PC;
			lr_init_out               <= RBC_LR_RESET;
		end
	end

	// ---------------------------------------------------------------
	// cause flags: reset sources latch, write one to clear, set wins
	// ---------------------------------------------------------------
	logic [RBC_NCAUSE-1:0] cause_set;
	logic [RBC_NCAUSE-1:0] cause_clr;
	logic                  wr_fire;
	logic                  rd_fire;
	logic [7:0]            aw_addr_reg;
	logic                  aw_have_reg;
	logic [31:0]           w_data_reg;
	logic                  w_have_reg;

	assign cause_set = {debug_reg[RBC_DBG_SYSREQ], s_lockup, s_sw || sw_req_reg, sack_reg, src_loc,
	                    s_watchdog_timer, src_pin, src_chip_por, s_por};
	assign wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid_out;
	assign cause_clr = (wr_fire && aw_addr_reg == RBC_CAUSE_ADDR) ? w_data_reg[RBC_NCAUSE-1:0] : '0;

	always_ff @(posedge mclk_in) begin
		if (!nrst_in)
			cause_reg <= '0;
		else if (src_any && state_reg == RBC_ST_RUN)
			cause_reg <= cause_set; // most recent cause replaces the previous one
		else
			cause_reg <= (cause_reg & ~cause_clr) | cause_set;
	end

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			aw_have_reg       <= 1'b0;
			w_have_reg        <= 1'b0;
			aw_addr_reg       <= '0;
			w_data_reg        <= '0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= 2'b00;
		end else begin
			s_axi_awready_out <= !aw_have_reg && !s_axi_awready_out;
			s_axi_wready_out  <= !w_have_reg && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_in;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= (aw_addr_reg > RBC_BOOT_ADDR || aw_addr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				aw_have_reg      <= 1'b0;
				w_have_reg       <= 1'b0;
			end
		end
	end

	// writable control registers
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || resets_out.chip_por) begin
			option_reg <= RBC_OPT_RESET;
			filter_reg <= RBC_FLT_RESET;
			clkgen_reg <= '0;
			vector_table_offset_reg_reg   <= '0;
		end else if (wr_fire) begin
			case (aw_addr_reg)
				RBC_OPTION_ADDR: option_reg <= w_data_reg[2:0];
				RBC_FILTER_ADDR: filter_reg <= w_data_reg[12:0];
				RBC_CLKGEN_ADDR: clkgen_reg <= w_data_reg[2:0];
				RBC_BOOT_ADDR:   vector_table_offset_reg_reg   <= {w_data_reg[31:7], 7'h00};
				default:         ;
			endcase
		end
	end

	// debug control survives software reset; software request clears on reset entry
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || resets_out.chip_por) begin
			debug_reg  <= '0;
			sw_req_reg <= 1'b0;
		end else begin
			sw_req_reg <= 1'b0;
			if (wr_fire && aw_addr_reg == RBC_DEBUG_ADDR)
				debug_reg <= w_data_reg[1:0];
			if (wr_fire && aw_addr_reg == RBC_SWRST_ADDR && w_data_reg[31:16] == RBC_SW_KEY)
				sw_req_reg <= w_data_reg[0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= '0;
			s_axi_rresp_out   <= 2'b00;
		end else if (s_axi_rvalid_out) begin
			if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= 2'b00;
			case (s_axi_araddr_in)
				RBC_CAUSE_ADDR:  s_axi_rdata_out <= {23'h000000, cause_reg};
				RBC_OPTION_ADDR: s_axi_rdata_out <= {29'h00000000, option_reg};
				RBC_FILTER_ADDR: s_axi_rdata_out <= {19'h00000, filter_reg};
				RBC_CLKGEN_ADDR: s_axi_rdata_out <= {29'h00000000, clkgen_reg};
				RBC_DEBUG_ADDR:  s_axi_rdata_out <= {30'h00000000, debug_reg};
				RBC_SWRST_ADDR:  s_axi_rdata_out <= 32'h0000_0000;
				RBC_BOOT_ADDR:   s_axi_rdata_out <= vector_table_offset_reg_reg;
				default: begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= 2'b10;
				end
			endcase
		end else begin
			s_axi_arready_out <= 1'b1;
		end
	end
endmodule : rbc_top
`default_nettype wire

//--- test/rbc_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_far_side (
	input  wire logic mclk_in,
	input  wire logic oe_n_in,
	input  wire logic hold_low_in,
	input  wire logic stop_req_in,
	output logic      pin_out,
	output logic      stop_ack_out
);
	logic [1:0] ack_dly;
	// pull-up: a released pin nobody pulls reads high
	assign pin_out = !(!oe_n_in || hold_low_in);
	// acknowledge late, but far inside the error limit
	always_ff @(posedge mclk_in) begin
		ack_dly <= {ack_dly[0], stop_req_in};
		stop_ack_out <= ack_dly[1];
	end
endmodule : rbc_far_side
`default_nettype wire

//--- test/rbc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_top_chk
	import rbc_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        nrst_in,
	input wire rbc_resets_t resets_out,
	input wire logic        shared_reset_pin_in,
	input wire logic        shared_reset_pin_oe_n_out,
	input wire logic        vec_fetch_out,
	input wire logic [31:0] vec_sp_addr_out,
	input wire logic [31:0] vec_pc_addr_out,
	input wire logic [31:0] lr_init_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// cleared by reset too, so a drive cut short never counts on
	logic [8:0] low_cnt;
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || shared_reset_pin_oe_n_out) low_cnt <= '0;
		else low_cnt <= low_cnt + 9'h1;
	end
	por_tiers_a: assert property (resets_out.por_only |-> resets_out.chip_por && resets_out.chip)
		else $error("por tier alone");
	chip_por_a: assert property (resets_out.chip_por |-> resets_out.early_chip && resets_out.chip)
		else $error("chip por tier alone");
	core_after_a: assert property (resets_out.chip |-> resets_out.core)
		else $error("core free before chip");
	drive_hold_a: assert property (!shared_reset_pin_oe_n_out |-> resets_out.chip)
		else $error("pin driven outside reset");
	drive_max_a: assert property (!shared_reset_pin_oe_n_out |-> low_cnt < 9'(RBC_PIN_DRIVE_CYC))
		else $error("pin drive too long");
	fetch_clean_a: assert property (vec_fetch_out |-> !resets_out.early_chip && !resets_out.core
		&& lr_init_out == RBC_LR_RESET && vec_pc_addr_out == vec_sp_addr_out + 32'h4) else $error("bad fetch");
	chip_pin_a: assert property ($fell(resets_out.chip) |-> shared_reset_pin_oe_n_out
		&& $past(shared_reset_pin_in, 2)) else $error("chip freed with pin low");
	fetch_late_a: assert property ($fell(resets_out.chip) |-> !vec_fetch_out [*8])
		else $error("fetch before flash init");
	read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read not answered");
	cover property (vec_fetch_out);
	cover property (resets_out.por_only);
	cover property ($rose(shared_reset_pin_oe_n_out) && low_cnt == 9'(RBC_PIN_DRIVE_CYC));
endmodule : rbc_top_chk
bind rbc_top rbc_top_chk chk (.mclk_in, .nrst_in, .resets_out, .shared_reset_pin_in, .shared_reset_pin_oe_n_out,
	.vec_fetch_out, .vec_sp_addr_out, .vec_pc_addr_out, .lr_init_out, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_rvalid_out);
`default_nettype wire

//--- test/rbc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rbc_top_tb;
	import rbc_pkg::*;
	logic        clk, nrst, awv, wv, brdy, arv, rrdy, sreq, lost, hold_low;
	logic        aw_r, w_r, bv, ar_r, rv, pin, oe_n, vf, sack, pe, cce, spo, cgd;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdt, rd, st, sp, pc, lr;
	logic [1:0]  br, rr, r;
	logic [2:0]  fn;
	rbc_req_t    req;
	rbc_resets_t rs;
	int          n_errors, n_tests, cyc, k;
	int          bits [6] = '{RBC_C_WATCHDOG_TIMER, RBC_C_LOCKUP, RBC_C_LVD, RBC_C_SW, RBC_C_PIN, RBC_C_LOC};
	rbc_top dut (.mclk_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(aw_r), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(w_r), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(ar_r), .s_axi_rdata_out(rdt),
		.s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .req_in(req),
		.stop_req_in(sreq), .stop_ack_in(sack), .ext_clk_lost_in(lost), .shared_reset_pin_in(pin),
		.shared_reset_pin_out(spo), .shared_reset_pin_oe_n_out(oe_n), .resets_out(rs), .core_clk_en_out(cce),
		.clkgen_default_out(cgd), .pins_enable_out(pe), .pin_fn_enable_out(fn), .vec_fetch_out(vf),
		.vec_sp_addr_out(sp), .vec_pc_addr_out(pc), .lr_init_out(lr));
	rbc_far_side far (.mclk_in(clk), .oe_n_in(oe_n), .hold_low_in(hold_low), .stop_req_in(sreq),
		.pin_out(pin), .stop_ack_out(sack));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [31:0] cause_of(input int b);
		return 32'h1 << b;
	endfunction : cause_of
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic close_out;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// one bus transfer; write when w is high, read otherwise
	task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs_o);
		int i;
		@(posedge clk);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		arv <= !w;
		brdy <= w;
		rrdy <= !w;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (aw_r) awv <= 1'b0;
			if (w_r) wv <= 1'b0;
			if (ar_r) arv <= 1'b0;
			if ((w && bv) || (!w && rv)) break;
		end
		chk({31'h0, i < 60}, 32'h1);
		rs_o = w ? br : rr;
		rd = rdt;
		brdy <= 1'b0;
		rrdy <= 1'b0;
	endtask : ax
	task automatic boot;
		int i;
		for (i = 0; i < 4000 && vf !== 1'b1; i++) @(negedge clk);
		chk({31'h0, vf}, 32'h1);
	endtask : boot
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			close_out();
		end
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		{awv, wv, brdy, arv, rrdy, sreq, lost, hold_low} = '0;
		{awa, ara, wd} = '0;
		{n_errors, n_tests, cyc} = '0;
		req = '0;
		req.por = 1'b1;
		st = 32'h436134ea;
		nrst = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		req <= '0;
		boot();
		ax(1'b0, RBC_CAUSE_ADDR, 32'h0, r);
		chk(rd, cause_of(RBC_C_POR) | cause_of(RBC_C_LVD));
		chk({29'h0, fn}, {29'h0, RBC_OPT_RESET});
		chk({31'h0, pe}, 32'h0);
		chk(sp, RBC_VEC_SP);
		chk(pc, RBC_VEC_PC);
		chk(lr, RBC_LR_RESET);
		chk({31'h0, cce}, 32'h1);
		ax(1'b1, RBC_CAUSE_ADDR, 32'h1ff, r);
		ax(1'b0, RBC_CAUSE_ADDR, 32'h0, r);
		chk(rd, 32'h0);
		ax(1'b1, 8'h1c, 32'h0, r);
		chk({30'h0, r}, 32'h2);
		st = xs(st);
		ax(1'b1, RBC_BOOT_ADDR, st & 32'hffff_ff80, r);
		ax(1'b0, RBC_BOOT_ADDR, 32'h0, r);
		chk(rd, st & 32'hffff_ff80);
		sreq <= 1'b1;
		repeat (200) @(posedge clk);
		chk({31'h0, rs.chip}, 32'h0);
		sreq <= 1'b0;
		for (k = 0; k < 6; k++) begin
			st = xs(st);
			case (k)
				0: req.watchdog_timer <= 1'b1;
				1: req.lockup <= 1'b1;
				2: req.low_voltage_detect <= 1'b1;
				3: ax(1'b1, RBC_SWRST_ADDR, {RBC_SW_KEY, 16'h1}, r);
				4: hold_low <= 1'b1;
				default: begin
					ax(1'b1, RBC_CLKGEN_ADDR, 32'h3, r);
					lost <= 1'b1;
				end
			endcase
			repeat (8 + st[4:0]) @(posedge clk);
			chk({31'h0, rs.chip}, 32'h1);
			chk({31'h0, rs.chip_por}, {31'h0, k == 2});
			chk({31'h0, rs.por_only}, 32'h0);
			chk({30'h0, spo, cgd}, 32'h1);
			req <= '0;
			hold_low <= 1'b0;
			lost <= 1'b0;
			boot();
			ax(1'b0, RBC_CAUSE_ADDR, 32'h0, r);
			chk(rd, cause_of(bits[k]));
		end
		ax(1'b1, RBC_DEBUG_ADDR, 32'h3, r);
		repeat (1500) @(posedge clk);
		chk({31'h0, rs.chip}, 32'h1);
		ax(1'b1, RBC_DEBUG_ADDR, 32'h2, r);
		repeat (1500) @(posedge clk);
		chk({30'h0, rs.chip, rs.core}, 32'h1);
		ax(1'b1, RBC_DEBUG_ADDR, 32'h0, r);
		boot();
		ax(1'b0, RBC_CAUSE_ADDR, 32'h0, r);
		chk(rd, cause_of(RBC_C_DAP));
		close_out();
	end
endmodule : rbc_top_tb
`default_nettype wire
